// ### hdl/sciq_cfg.svh
/*
  offsets, field positions, reset values and pin idle levels of the serial
  mode and interrupt block. assumes inclusion by bare name ahead of any use.
*/
`default_nettype none
`ifndef SCIQ_CFG_SVH
`define SCIQ_CFG_SVH
`define SCIQ_ADDR_FLAGS   32'h4000a808
`define SCIQ_ADDR_ENABLES 32'h4000a848
`define SCIQ_ADDR_STYLE   32'h4000a854
`define SCIQ_ADDR_MODE    32'h4000c854
`define SCIQ_ADDR_FLOW    32'h4000c860
`define SCIQ_EVT_MASK     15'h7e1f
`define SCIQ_BIT_PARERR   14
`define SCIQ_BIT_FRMERR   13
`define SCIQ_BIT_TXDMAB   12
`define SCIQ_BIT_TXDMAA   11
`define SCIQ_BIT_RXDMAB   10
`define SCIQ_BIT_RXDMAA   9
`define SCIQ_BIT_TXUND    4
`define SCIQ_BIT_RXOVF    3
`define SCIQ_BIT_TXIDLE   2
`define SCIQ_BIT_TXFREE   1
`define SCIQ_BIT_RXVAL    0
`define SCIQ_MODE_OFF     2'h0
`define SCIQ_MODE_UART    2'h1
`define SCIQ_MODE_SPI     2'h2
`define SCIQ_FLAGS_RESET  15'h0000
`define SCIQ_ENABLE_RESET 15'h0000
`define SCIQ_STYLE_RESET  3'h0
`define SCIQ_FLOW_RESET   1'h0
`define SCIQ_RESP_OKAY    2'h0
`define SCIQ_RESP_SLVERR  2'h2
`define SCIQ_PIN_IDLE     3'h4
`endif
`default_nettype wire

// ### hdl/sciq_pkg.sv
/*
  types of the serial mode and interrupt block: write phase and state record.
  assumes sciq_cfg.svh for nothing; widths here are fixed by the register map.
*/
`default_nettype none
package sciq_pkg;
  typedef enum logic {SCIQ_WR_COLLECT, SCIQ_WR_RESP} sciq_wr_t;

  typedef struct packed {
    sciq_wr_t    wrPhase;
    logic        awReady;
    logic        wReady;
    logic        awHeld;
    logic        wHeld;
    logic [31:0] awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    logic [14:0] flags;
    logic [14:0] enables;
    logic [2:0]  style;
    logic [1:0]  mode;
    logic        flowCtl;
    logic [2:0]  prevLevel;
    logic        irq;
    logic        spiActive;
    logic        uartActive;
    logic        pb1Out;
    logic        pb1Oe;
    logic        pb4Out;
    logic        pb4Oe;
    logic        slaveIn;
    logic        spiClk;
    logic        spiClkRise;
    logic        spiClkFall;
    logic        slaveSelN;
    logic        uartRx;
    logic        ctsN;
  } sciq_state_t;
endpackage
`default_nettype wire

// ### hdl/sciq_pin_if.sv
/*
  carrier between the pin synchroniser and the main block.
  assumes both ends run on ref_clk.
*/
`default_nettype none
interface sciq_pin_if #(parameter int WIDTH = 3);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] rise;
  logic [WIDTH-1:0] fall;
  modport sync (input raw, output level, output rise, output fall);
  modport user (output raw, input level, input rise, input fall);
endinterface
`default_nettype wire

// ### hdl/sciq_pin_sync.sv
/*
  three-stage synchroniser with agreement filter and edge pulses for pin inputs.
  assumes raw pins are asynchronous to ref_clk; reset is synchronous, active high.
*/
`default_nettype none
module sciq_pin_sync #(
  parameter int               WIDTH = 3,
  parameter logic [WIDTH-1:0] IDLE  = '0
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  sciq_pin_if.sync pins
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
  } sciq_sync_t;

  sciq_sync_t syncReg;
  sciq_sync_t syncNext;

  if (WIDTH < 1)
  begin : g_width_check
    $error("sciq_pin_sync needs at least one line");
  end

  // s1 is seen by s2 only; the filter looks at s2 and s3
  always_comb
  begin
    syncNext = syncReg;
    syncNext.s1 = pins.raw;
    syncNext.s2 = syncReg.s1;
    syncNext.s3 = syncReg.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (syncReg.s2[i] == syncReg.s3[i])
      begin
        syncNext.level[i] = syncReg.s3[i];
      end
      syncNext.rise[i] = (syncReg.s2[i] == syncReg.s3[i]) && syncReg.s3[i] && !syncReg.level[i];
      syncNext.fall[i] = (syncReg.s2[i] == syncReg.s3[i]) && !syncReg.s3[i] && syncReg.level[i];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      syncReg <= '{s1: IDLE, s2: IDLE, s3: IDLE, level: IDLE, rise: '0, fall: '0};
    end
    else
    begin
      syncReg <= syncNext;
    end
  end

  assign pins.level = syncReg.level;
  assign pins.rise  = syncReg.rise;
  assign pins.fall  = syncReg.fall;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_sync_agree_level: assert property (
    (syncReg.level != $past(syncReg.level)) |-> ($past(syncReg.s2) == $past(syncReg.s3)))
    else $error("synchronised level moved without agreement");
  a_sync_rise_pulse: assert property (
    (|syncReg.rise) |-> ((syncReg.level & syncReg.rise) == syncReg.rise) ##1 ((syncReg.rise & $past(syncReg.rise)) == '0))
    else $error("rise pulse mismatch");
endmodule // sciq_pin_sync
`default_nettype wire

// ### hdl/sciq_top.sv
/*
  serial controller mode selection, pin roles and interrupt bookkeeping
  behind an axi4-lite slave. assumes shift engines, fifos and dma on ref_clk
  deliver event pulses and status levels; pins pb2..pb4 are asynchronous.
*/
// Added by the designer: register access over AXI4-Lite.
`include "sciq_cfg.svh"
`default_nettype none
module sciq_top (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        parityErrorEvent,
  input  wire logic        framingErrorEvent,
  input  wire logic        txDmaBufBDone,
  input  wire logic        txDmaBufADone,
  input  wire logic        rxDmaBufBDone,
  input  wire logic        rxDmaBufADone,
  input  wire logic        txUnderrunEvent,
  input  wire logic        rxOverrunEvent,
  input  wire logic        txIdleEvent,
  input  wire logic        txSpaceEvent,
  input  wire logic        rxHasByteEvent,
  input  wire logic        slaveOutLine,
  input  wire logic        uartTxLine,
  input  wire logic        requestToSendLineN,
  input  wire logic        pb2In,
  input  wire logic        pb3In,
  input  wire logic        pb4In,
  output var  logic        pb1Out,
  output var  logic        pb1Oe,
  output var  logic        pb4Out,
  output var  logic        pb4Oe,
  output var  logic        spiSelect,
  output var  logic        uartSelect,
  output var  logic        slaveInLine,
  output var  logic        spiClockLine,
  output var  logic        spiClockRise,
  output var  logic        spiClockFall,
  output var  logic        slaveSelectLineN,
  output var  logic        uartRxLine,
  output var  logic        clearToSendLineN,
  output var  logic        serialIrq
);
  sciq_pkg::sciq_state_t stateReg;
  sciq_pkg::sciq_state_t stateNext;
  logic [31:0]           laneMask;
  logic [14:0]           setMask;
  logic [14:0]           clrMask;
  logic [2:0]            levelNow;
  logic                  flagWrite;

  sciq_pin_if #(.WIDTH(3)) pins ();

  sciq_pin_sync #(
    .WIDTH (3),
    .IDLE  (`SCIQ_PIN_IDLE)
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pins    (pins)
  );

  assign pins.raw = {pb4In, pb3In, pb2In};

  function automatic logic [31:0] lanes(input logic [3:0] strb);
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic isMapped(input logic [31:0] addr);
    isMapped = (addr == `SCIQ_ADDR_FLAGS) || (addr == `SCIQ_ADDR_ENABLES) ||
               (addr == `SCIQ_ADDR_STYLE) || (addr == `SCIQ_ADDR_MODE) ||
               (addr == `SCIQ_ADDR_FLOW);
  endfunction

  always_comb
  begin
    stateNext = stateReg;
    laneMask  = lanes(stateReg.wStrb);
    clrMask   = '0;
    flagWrite = 1'b0;
    levelNow  = {txIdleEvent, txSpaceEvent, rxHasByteEvent};

    // write address and data are taken in either order
    if (s_axi_awvalid && stateReg.awReady)
    begin
      stateNext.awHeld = 1'b1;
      stateNext.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && stateReg.wReady)
    begin
      stateNext.wHeld = 1'b1;
      stateNext.wData = s_axi_wdata;
      stateNext.wStrb = s_axi_wstrb;
    end
    if (stateReg.wrPhase == sciq_pkg::SCIQ_WR_COLLECT && stateReg.awHeld && stateReg.wHeld)
    begin
      stateNext.awHeld  = 1'b0;
      stateNext.wHeld   = 1'b0;
      stateNext.bValid  = 1'b1;
      stateNext.wrPhase = sciq_pkg::SCIQ_WR_RESP;
      stateNext.bResp   = isMapped(stateReg.awAddr) ? `SCIQ_RESP_OKAY : `SCIQ_RESP_SLVERR;
      case (stateReg.awAddr)
        `SCIQ_ADDR_FLAGS:
        begin
          flagWrite = 1'b1;
          clrMask   = stateReg.wData[14:0] & laneMask[14:0];
        end
        `SCIQ_ADDR_ENABLES:
        begin
          stateNext.enables = ((stateReg.enables & ~laneMask[14:0]) |
                               (stateReg.wData[14:0] & laneMask[14:0])) & `SCIQ_EVT_MASK;
        end
        `SCIQ_ADDR_STYLE:
        begin
          stateNext.style = (stateReg.style & ~laneMask[2:0]) |
                            (stateReg.wData[2:0] & laneMask[2:0]);
        end
        `SCIQ_ADDR_MODE:
        begin
          // engines start only here, so earlier setup is complete by then
          stateNext.mode = (stateReg.mode & ~laneMask[1:0]) |
                           (stateReg.wData[1:0] & laneMask[1:0]);
        end
        `SCIQ_ADDR_FLOW:
        begin
          stateNext.flowCtl = (stateReg.flowCtl & ~laneMask[0]) |
                              (stateReg.wData[0] & laneMask[0]);
        end
        default:
        begin
          stateNext.bResp = `SCIQ_RESP_SLVERR;
        end
      endcase
    end
    if (stateReg.bValid && s_axi_bready)
    begin
      stateNext.bValid  = 1'b0;
      stateNext.wrPhase = sciq_pkg::SCIQ_WR_COLLECT;
    end
    stateNext.awReady = !stateNext.awHeld && !stateNext.bValid;
    stateNext.wReady  = !stateNext.wHeld && !stateNext.bValid;

    // reads never disturb state; flags stay visible with enables clear
    if (s_axi_arvalid && stateReg.arReady)
    begin
      stateNext.rValid = 1'b1;
      stateNext.rResp  = isMapped(s_axi_araddr) ? `SCIQ_RESP_OKAY : `SCIQ_RESP_SLVERR;
      case (s_axi_araddr)
        `SCIQ_ADDR_FLAGS:   stateNext.rData = {17'h00000, stateReg.flags};
        `SCIQ_ADDR_ENABLES: stateNext.rData = {17'h00000, stateReg.enables};
        `SCIQ_ADDR_STYLE:   stateNext.rData = {29'h00000000, stateReg.style};
        `SCIQ_ADDR_MODE:    stateNext.rData = {30'h00000000, stateReg.mode};
        `SCIQ_ADDR_FLOW:    stateNext.rData = {31'h00000000, stateReg.flowCtl};
        default:            stateNext.rData = 32'h00000000;
      endcase
    end
    else if (stateReg.rValid && s_axi_rready)
    begin
      stateNext.rValid = 1'b0;
    end
    stateNext.arReady = !stateNext.rValid;

    // fifo and dma events reach the same flags in either mode
    setMask = '0;
    setMask[`SCIQ_BIT_PARERR] = parityErrorEvent;
    setMask[`SCIQ_BIT_FRMERR] = framingErrorEvent;
    setMask[`SCIQ_BIT_TXDMAB] = txDmaBufBDone;
    setMask[`SCIQ_BIT_TXDMAA] = txDmaBufADone;
    setMask[`SCIQ_BIT_RXDMAB] = rxDmaBufBDone;
    setMask[`SCIQ_BIT_RXDMAA] = rxDmaBufADone;
    setMask[`SCIQ_BIT_TXUND]  = txUnderrunEvent;
    setMask[`SCIQ_BIT_RXOVF]  = rxOverrunEvent;
    for (int i = 0; i < 3; i++)
    begin
      // level style keeps re-setting the flag while the condition lasts
      setMask[i] = stateReg.style[i] ? levelNow[i] : (levelNow[i] && !stateReg.prevLevel[i]);
    end
    stateNext.prevLevel = levelNow;
    // a set in the clearing cycle wins
    stateNext.flags = ((stateReg.flags & ~clrMask) | setMask) & `SCIQ_EVT_MASK;
    stateNext.irq   = |(stateReg.flags & stateReg.enables);

    stateNext.spiActive  = (stateReg.mode == `SCIQ_MODE_SPI);
    stateNext.uartActive = (stateReg.mode == `SCIQ_MODE_UART);
    // slave out is driven even while deselected
    stateNext.pb1Oe  = stateNext.spiActive || stateNext.uartActive;
    stateNext.pb1Out = stateNext.spiActive ? slaveOutLine :
                       (stateNext.uartActive ? uartTxLine : 1'b1);
    // clock and select are never driven: pb3 has no driver, pb4 only in uart
    stateNext.pb4Oe  = stateNext.uartActive && stateReg.flowCtl;
    stateNext.pb4Out = stateNext.pb4Oe ? requestToSendLineN : 1'b1;
    stateNext.slaveIn    = stateNext.spiActive && pins.level[0];
    stateNext.spiClk     = stateNext.spiActive && pins.level[1];
    stateNext.spiClkRise = stateNext.spiActive && pins.rise[1];
    stateNext.spiClkFall = stateNext.spiActive && pins.fall[1];
    stateNext.slaveSelN  = !stateNext.spiActive || pins.level[2];
    stateNext.uartRx     = !stateNext.uartActive || pins.level[0];
    stateNext.ctsN       = !(stateNext.uartActive && stateReg.flowCtl) || pins.level[1];
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      stateReg         <= '0;
      stateReg.wrPhase <= sciq_pkg::SCIQ_WR_COLLECT;
      stateReg.flags   <= `SCIQ_FLAGS_RESET;
      stateReg.enables <= `SCIQ_ENABLE_RESET;
      stateReg.style   <= `SCIQ_STYLE_RESET;
      stateReg.mode    <= `SCIQ_MODE_OFF;
      stateReg.flowCtl <= `SCIQ_FLOW_RESET;
      stateReg.pb1Out  <= 1'b1;
      stateReg.pb4Out  <= 1'b1;
      stateReg.slaveSelN <= 1'b1;
      stateReg.uartRx  <= 1'b1;
      stateReg.ctsN    <= 1'b1;
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  assign s_axi_awready    = stateReg.awReady;
  assign s_axi_wready     = stateReg.wReady;
  assign s_axi_bresp      = stateReg.bResp;
  assign s_axi_bvalid     = stateReg.bValid;
  assign s_axi_arready    = stateReg.arReady;
  assign s_axi_rdata      = stateReg.rData;
  assign s_axi_rresp      = stateReg.rResp;
  assign s_axi_rvalid     = stateReg.rValid;
  assign pb1Out           = stateReg.pb1Out;
  assign pb1Oe            = stateReg.pb1Oe;
  assign pb4Out           = stateReg.pb4Out;
  assign pb4Oe            = stateReg.pb4Oe;
  assign spiSelect        = stateReg.spiActive;
  assign uartSelect       = stateReg.uartActive;
  assign slaveInLine      = stateReg.slaveIn;
  assign spiClockLine     = stateReg.spiClk;
  assign spiClockRise     = stateReg.spiClkRise;
  assign spiClockFall     = stateReg.spiClkFall;
  assign slaveSelectLineN = stateReg.slaveSelN;
  assign uartRxLine       = stateReg.uartRx;
  assign clearToSendLineN = stateReg.ctsN;
  assign serialIrq        = stateReg.irq;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_mode_decode_spi: assert property (
    ##1 (spiSelect == ($past(stateReg.mode) == `SCIQ_MODE_SPI)) && !(spiSelect && uartSelect))
    else $error("mode decode wrong");
  a_spi_no_drive: assert property (
    spiSelect |-> !pb4Oe)
    else $error("spi slave drives pb4");
  a_spi_pin_roles: assert property (
    $rose(spiSelect) |-> pb1Oe ##1 pb1Oe [*2])
    else $error("slave out not driven in spi");
  a_uart_flow_pin: assert property (
    pb4Oe |-> (uartSelect && $past(stateReg.flowCtl)))
    else $error("pb4 driven outside uart flow control");
  a_parity_sets: assert property (
    parityErrorEvent |=> stateReg.flags[`SCIQ_BIT_PARERR] ##1 serialIrq == $past(|(stateReg.flags & stateReg.enables)))
    else $error("parity flag or irq not set");
  a_dma_sets: assert property (
    (txDmaBufBDone || txDmaBufADone) |=>
      ((stateReg.flags[`SCIQ_BIT_TXDMAB] || !$past(txDmaBufBDone)) &&
       (stateReg.flags[`SCIQ_BIT_TXDMAA] || !$past(txDmaBufADone))))
    else $error("dma flags not set");
  a_overrun_sets: assert property (
    (rxOverrunEvent || txUnderrunEvent) |=>
      ((stateReg.flags[`SCIQ_BIT_RXOVF] || !$past(rxOverrunEvent)) &&
       (stateReg.flags[`SCIQ_BIT_TXUND] || !$past(txUnderrunEvent))))
    else $error("overrun or underrun flag missing");
  a_edge_once: assert property (
    (!stateReg.style[0] && stateReg.prevLevel[0] && rxHasByteEvent && !stateReg.flags[0] && !flagWrite)
      |=> !stateReg.flags[0])
    else $error("edge style flag set on steady level");
  a_level_resets: assert property (
    (stateReg.style[2] && txIdleEvent) |=> stateReg.flags[`SCIQ_BIT_TXIDLE])
    else $error("level style idle flag not set");
  a_enable_layout: assert property (
    (stateReg.enables & ~`SCIQ_EVT_MASK) == 15'h0000)
    else $error("reserved enable bit set");
  a_w1c_clear: assert property (
    (flagWrite && clrMask[`SCIQ_BIT_FRMERR] && !framingErrorEvent) |=> !stateReg.flags[`SCIQ_BIT_FRMERR])
    else $error("write one did not clear flag");
  a_irq_follow: assert property (
    (|(stateReg.flags & stateReg.enables)) |=> serialIrq)
    else $error("irq not raised");
  a_bresp_hold: assert property (
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped");

  c_spi_entry: cover property ($rose(spiSelect) ##[1:20] spiClockRise);
  c_irq_raise: cover property ($rose(serialIrq));
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready && s_axi_rdata != 32'h00000000);
endmodule // sciq_top
`default_nettype wire

// ### sim/sciq_spi_peer.sv
/*
  behavioural spi master on the far side of the serial pins.
  assumes the bench pulses start only while the previous frame is over.
*/
`default_nettype none
module sciq_spi_peer (
  input  wire logic       start,
  input  wire logic [7:0] txByte,
  output var  logic       sclk,
  output var  logic       mosi,
  output var  logic       ssN
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {sclk, mosi, ssN} = 3'h1;
  end
  // master owns clock and select; clock stands still between frames
  always @(posedge start)
  begin
    ssN = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      mosi = txByte[i];
      #32 sclk = 1'b1;
      #32 sclk = 1'b0;
    end
    #32 ssN = 1'b1;
    mosi = ~mosi;  // line left at the inverse of the last bit sent
  end
endmodule // sciq_spi_peer
`default_nettype wire

// ### sim/tb_top.sv
/*
  self-checking bench of the serial mode and interrupt block.
  assumes sciq_top on a 200 MHz ref_clk and the spi master model on the pins.
*/
`include "sciq_cfg.svh"
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rdat, en;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [14:0] evt = '0;
  logic [2:0]  drv = '0;  // slave-out, uart tx, rts_n from the engines
  logic [7:0]  txByte = '0, gotByte = '0;
  logic        go = 1'b0, sclk, mosi, ssN;
  logic        pb1Out, pb1Oe, pb4Out, pb4Oe, spiSel, uartSel, sIn, sRise, ssLine, ctsN, irq;
  logic        sClk, sFall, uRx;
  int          n_fail = 0, checks_done = 0, cyc = 0, nRise = 0, nFall = 0, seed = 32'hab95;
  int          bits[11] = '{14, 13, 12, 11, 10, 9, 4, 3, 2, 1, 0};

  sciq_top i_sciq_top (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .parityErrorEvent(evt[14]), .framingErrorEvent(evt[13]),
    .txDmaBufBDone(evt[12]), .txDmaBufADone(evt[11]), .rxDmaBufBDone(evt[10]),
    .rxDmaBufADone(evt[9]), .txUnderrunEvent(evt[4]), .rxOverrunEvent(evt[3]),
    .txIdleEvent(evt[2]), .txSpaceEvent(evt[1]), .rxHasByteEvent(evt[0]),
    .slaveOutLine(drv[2]), .uartTxLine(drv[1]), .requestToSendLineN(drv[0]),
    .pb2In(mosi), .pb3In(sclk), .pb4In(ssN), .pb1Out(pb1Out), .pb1Oe(pb1Oe),
    .pb4Out(pb4Out), .pb4Oe(pb4Oe), .spiSelect(spiSel), .uartSelect(uartSel),
    .slaveInLine(sIn), .spiClockLine(sClk), .spiClockRise(sRise), .spiClockFall(sFall),
    .slaveSelectLineN(ssLine), .uartRxLine(uRx), .clearToSendLineN(ctsN), .serialIrq(irq));

  sciq_spi_peer i_sciq_spi_peer (.start(go), .txByte(txByte), .sclk(sclk), .mosi(mosi),
    .ssN(ssN));

  always #2.5 ref_clk = ~ref_clk;

  function automatic logic [31:0] flagOf(input int b);
    return 32'h1 << b;
  endfunction

  function automatic logic [31:0] legal(input logic [31:0] v);
    return v & {17'h0, `SCIQ_EVT_MASK};
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
      resp = bresp;
    end
    while (!bvalid);
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do
    begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      {rdat, resp} = {rdata, rresp};
    end
    while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
    rd(a);
    `CHK({rdat, resp}, {e, `SCIQ_RESP_OKAY})
  endtask

  task automatic pulse(input int b);
    @(posedge ref_clk);
    evt[b] <= 1'b1;
    @(posedge ref_clk);
    evt[b] <= 1'b0;
  endtask

  // slave-in bits gathered msb first at each seen clock rise
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (sRise) nRise <= nRise + 1;
    if (sRise) gotByte <= {gotByte[6:0], sIn};
    if (sFall) nFall <= nFall + 1;
    if (sRise) `CHK(sClk, 1'b1)
    if (cyc == 5000)
    begin
      n_fail++;
      conclude();
    end
  end

  initial
  begin
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    waitc(2);
    `CHK({pb1Oe, pb4Oe, spiSel, uartSel, irq}, 5'h0)
    rdchk(`SCIQ_ADDR_MODE, 32'h0);
    rdchk(`SCIQ_ADDR_ENABLES, 32'h0);
    rdchk(`SCIQ_ADDR_FLAGS, 32'h0);
    rdchk(`SCIQ_ADDR_STYLE, 32'h0);
    wr(`SCIQ_ADDR_STYLE, 32'h0);
    en = $random(seed);
    wr(`SCIQ_ADDR_ENABLES, en);
    en = legal(en);
    rdchk(`SCIQ_ADDR_ENABLES, en);
    foreach (bits[i])
    begin
      pulse(bits[i]);
      waitc(2);
      `CHK(irq, en[bits[i]])
      rdchk(`SCIQ_ADDR_FLAGS, flagOf(bits[i]));
      wr(`SCIQ_ADDR_FLAGS, ~flagOf(bits[i]));
      rdchk(`SCIQ_ADDR_FLAGS, flagOf(bits[i]));
      wr(`SCIQ_ADDR_FLAGS, flagOf(bits[i]));
      rdchk(`SCIQ_ADDR_FLAGS, 32'h0);
      `CHK(irq, 1'b0)
    end
    // level style re-sets a flag cleared while its source stays high
    wr(`SCIQ_ADDR_STYLE, 32'h7);
    rdchk(`SCIQ_ADDR_STYLE, 32'h7);
    evt[2:0] <= 3'h7;
    wr(`SCIQ_ADDR_FLAGS, 32'h7);
    rdchk(`SCIQ_ADDR_FLAGS, 32'h7);
    wr(`SCIQ_ADDR_STYLE, 32'h0);
    wr(`SCIQ_ADDR_FLAGS, 32'h7);
    rdchk(`SCIQ_ADDR_FLAGS, 32'h0);
    evt[2:0] <= 3'h0;
    drv <= 3'($random(seed));
    wr(`SCIQ_ADDR_MODE, {30'h0, `SCIQ_MODE_SPI});
    waitc(2);
    `CHK({spiSel, uartSel, pb1Oe, pb4Oe, pb1Out}, {4'ha, drv[2]})
    rdchk(`SCIQ_ADDR_MODE, 32'h2);
    txByte <= 8'($random(seed));
    go <= 1'b1;
    waitc(20);
    `CHK(ssLine, 1'b0)
    go <= 1'b0;
    for (int k = 0; k < 200 && !ssN; k++) @(posedge ref_clk);
    waitc(8);
    `CHK(nRise, 8)
    `CHK(nFall, 8)
    `CHK(gotByte, txByte)
    wr(`SCIQ_ADDR_MODE, 32'h0);
    waitc(2);
    `CHK({spiSel, uartSel, pb1Oe}, 3'h0)
    wr(`SCIQ_ADDR_MODE, {30'h0, `SCIQ_MODE_UART});
    waitc(2);
    `CHK({spiSel, uartSel, pb1Oe, pb4Oe, pb1Out}, {4'h6, drv[1]})
    `CHK(uRx, ~txByte[0])
    wr(`SCIQ_ADDR_MODE, 32'h0);
    wr(`SCIQ_ADDR_FLOW, 32'h1);
    wr(`SCIQ_ADDR_MODE, {30'h0, `SCIQ_MODE_UART});
    waitc(8);
    `CHK({pb4Oe, pb4Out, ctsN}, {1'b1, drv[0], 1'b0})
    wr(32'h4000a80c, 32'hffffffff);
    `CHK(resp, `SCIQ_RESP_SLVERR)
    rd(32'h4000a80c);
    `CHK({rdat, resp}, {32'h0, `SCIQ_RESP_SLVERR})
    conclude();
  end
endmodule // tb_top
`default_nettype wire
